// >>> dv/dpa_arbiter_chk.sv
/* dpa_arbiter_chk.sv: port-level checks on the dual-port arbiter.
   Assumes it is bound onto dpa_arbiter and sees only its ports. */
`timescale 1ns/100ps
`default_nettype none
module dpa_arbiter_chk (
  input wire logic       sys_clk,
  input wire logic       rstn,
  input wire logic       cpu_done,
  input wire logic       cpu_ready,
  input wire logic       cpu_ram_sel,
  input wire logic       cpu_rom_sel,
  input wire logic       cpu_ext_sel,
  input wire logic       cpu_grant,
  input wire logic       sys_grant,
  input wire logic [15:0] ram_addr,
  input wire logic [1:0] arb_state,
  input wire logic       cpu_rst,
  input wire logic       sys_init_n
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  property p_states; arb_state != 2'h3; endproperty
  a_states: assert property (p_states) else $error("bad arbiter state");
  property p_owner; !(cpu_grant && sys_grant); endproperty
  a_owner: assert property (p_owner) else $error("both sides granted");
  property p_idle; arb_state == 2'h0 |-> cpu_grant && !sys_grant; endproperty
  a_idle: assert property (p_idle) else $error("idle bus not with processor");
  property p_sys; sys_grant |-> arb_state == 2'h2; endproperty
  a_sys: assert property (p_sys) else $error("system grant outside busy state");
  property p_pulse; cpu_ready |=> !cpu_ready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
  property p_sel; $onehot0({cpu_ram_sel, cpu_rom_sel, cpu_ext_sel}); endproperty
  a_sel: assert property (p_sel) else $error("two regions decoded");
  property p_wait; arb_state == 2'h2 && cpu_ram_sel |-> !cpu_ready; endproperty
  a_wait: assert property (p_wait) else $error("ram ready while system busy");
  property p_done; arb_state == 2'h1 && cpu_done |-> ##[1:2] arb_state != 2'h1; endproperty
  a_done: assert property (p_done) else $error("busy state kept after done");
  property p_init; cpu_rst == !sys_init_n; endproperty
  a_init: assert property (p_init) else $error("init and reset disagree");
  property p_rst; $rose(rstn) |-> arb_state == 2'h0 && cpu_rst && !sys_grant; endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_addr; arb_state == 2'h2 && $past(arb_state) == 2'h2 |-> $stable(ram_addr); endproperty
  a_addr: assert property (p_addr) else $error("ram address moved during system use");
endmodule // dpa_arbiter_chk
bind dpa_arbiter dpa_arbiter_chk u_dpa_arbiter_chk (.*);
`default_nettype wire

// >>> dv/dpa_sys_master.sv
/* dpa_sys_master.sv: backplane master asking for the slave window.
   Assumes the bench raises go with addr; request drops with done HOLD+1 cycles after the grant is seen. */
`timescale 1ns/100ps
`default_nettype none
module dpa_sys_master #(
  parameter int HOLD = 8
) (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        go,
  input  wire logic [19:0] addr,
  input  wire logic        sys_grant,
  output var  logic        sys_req,
  output var  logic        sys_wr,
  output var  logic        sys_byte,
  output var  logic        sys_done,
  output var  logic [19:0] sys_addr
);
  logic [1:0] st_r;
  int         cnt_r;
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= 2'h0;
      cnt_r <= 0;
      sys_req <= 1'b0;
      sys_wr <= 1'b0;
      sys_byte <= 1'b0;
      sys_done <= 1'b0;
      sys_addr <= 20'h0;
    end else begin
      case (st_r)
        2'h0: if (go) begin
          sys_req <= 1'b1;
          sys_wr <= 1'b1;
          sys_byte <= 1'b1;
          sys_addr <= addr;
          st_r <= 2'h1;
        end
        2'h1: if (!go) begin
          sys_req <= 1'b0;
          st_r <= 2'h3;
        end else if (sys_grant) begin
          cnt_r <= 0;
          st_r <= 2'h2;
        end
        2'h2: begin
          cnt_r <= cnt_r + 1;
          if (cnt_r == HOLD) begin
            sys_done <= 1'b1;
            sys_req <= 1'b0;
            st_r <= 2'h3;
          end
        end
        default: begin
          // released address lines wander so stale values are never trusted
          sys_addr <= ~sys_addr;
          // done stays up until the arbiter drops the grant
          if (!sys_grant) sys_done <= 1'b0;
          if (!go && !sys_grant) st_r <= 2'h0;
        end
      endcase
    end
  end
endmodule // dpa_sys_master
`default_nettype wire

// >>> dv/tb.sv
/* tb.sv: self-checking bench for dpa_arbiter with a backplane master.
   Assumes a 25 MHz sys_clk; the bench drives the processor side. */
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic sys_clk = 1'b0, rstn = 1'b0, aux_rst_n = 1'b1, go = 1'b0;
  logic cpu_req = 1'b0, cpu_wr = 1'b0, cpu_io = 1'b0, cpu_done = 1'b0;
  logic exp_eprom_fit = 1'b0, exp_ram_fit = 1'b0;
  logic [19:0] cpu_addr = 20'h0, m_addr = 20'h0, sys_addr;
  logic [1:0] rom_size_sel = 2'h0, arb_state;
  logic [6:0] slv_base_sw = 7'h08;
  logic [3:0] slv_size_sw = 4'h2;
  logic [15:0] ram_addr;
  logic sys_req, sys_wr, sys_byte, sys_done, cpu_ready, cpu_ram_sel, cpu_rom_sel;
  logic cpu_ext_sel, cpu_grant, sys_grant, sys_hit, sys_byte_xfer, cpu_rst, sys_init_n;
  int error_cnt = 0, n_compared = 0, cyc = 0;
  always #20 sys_clk = ~sys_clk;
  dpa_arbiter u_dpa_arbiter (.*);
  dpa_sys_master u_dpa_sys_master (.sys_clk, .rstn, .go, .addr(m_addr), .sys_grant,
    .sys_req, .sys_wr, .sys_byte, .sys_done, .sys_addr);
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wait_for(ref logic s, input logic v, input int lim);
    int c;
    c = 0;
    while (s !== v && c < lim) begin
      @(negedge sys_clk);
      c++;
    end
  endtask
  // n: edges from request to ready, 0 skips it; ext cycles raise done once the exchange is due
  task automatic cpu_op(input logic [19:0] a, input logic w, input logic io,
                        input logic [2:0] sel, input int n);
    int c;
    c = 0;
    cpu_addr = a;
    cpu_wr = w;
    cpu_io = io;
    cpu_req = 1'b1;
    do begin
      @(negedge sys_clk);
      c++;
      // decode outputs stand only until ready, so they are judged on the first edge
      if (c == 1) chk({cpu_ram_sel, cpu_rom_sel, cpu_ext_sel}, sel);
      if (sel[0] && c == 5) cpu_done = 1'b1;
    end while (cpu_ready !== 1'b1 && c < 60);
    chk(cpu_ready, 1'b1);
    if (sel[0]) chk(arb_state, 2'h0);
    // 40 ns per edge against the minimum exchange overhead
    if (sel[0]) chk(c * 40 >= 200, 1'b1);
    if (sel[2]) chk(sys_grant, 1'b0);
    if (sel[2]) chk(arb_state, 2'h1);
    if (n > 0) chk(c, n);
    cpu_req = 1'b0;
    cpu_done = 1'b1;
    @(negedge sys_clk);
    cpu_done = 1'b0;
    repeat (8) @(negedge sys_clk);
  endtask
  task automatic t_map;
    cpu_op(20'hFF000, 1'b0, 1'b0, 3'b010, 3);
    cpu_op(20'hFEFFF, 1'b0, 1'b0, 3'b001, 0);
    rom_size_sel = 2'h1;
    cpu_op(20'hFE000, 1'b0, 1'b0, 3'b010, 3);
    rom_size_sel = 2'h2;
    cpu_op(20'hFC000, 1'b0, 1'b0, 3'b010, 3);
    cpu_op(20'hFFFF0, 1'b0, 1'b0, 3'b010, 3);
    exp_eprom_fit = 1'b1;
    cpu_op(20'hF8000, 1'b0, 1'b0, 3'b010, 3);
    cpu_op(20'h00000, 1'b0, 1'b0, 3'b100, 4);
    cpu_op(20'h07FFF, 1'b1, 1'b0, 3'b100, 5);
    cpu_op(20'h08000, 1'b0, 1'b0, 3'b001, 0);
    cpu_op(20'h00040, 1'b0, 1'b1, 3'b000, 3);
    exp_ram_fit = 1'b1;
    cpu_op(20'h0FFFF, 1'b0, 1'b0, 3'b100, 4);
    exp_ram_fit = 1'b0;
    $display("test map done");
  endtask
  task automatic refuse(input logic [19:0] a);
    m_addr = a;
    go = 1'b1;
    repeat (16) @(negedge sys_clk);
    chk(sys_hit, 1'b0);
    chk(sys_grant, 1'b0);
    go = 1'b0;
    repeat (4) @(negedge sys_clk);
  endtask
  task automatic t_sys;
    m_addr = 20'h10123;
    go = 1'b1;
    wait_for(sys_grant, 1'b1, 12);
    chk(sys_grant, 1'b1);
    chk(ram_addr, 16'h0123);
    chk(sys_byte_xfer, 1'b1);
    chk(sys_hit, 1'b1);
    chk(cpu_grant, 1'b0);
    cpu_op(20'h00010, 1'b0, 1'b0, 3'b100, 0);
    go = 1'b0;
    repeat (4) @(negedge sys_clk);
    refuse(20'h14000);
    slv_base_sw = 7'h0E;
    slv_size_sw = 4'h4;
    refuse(20'h20010);
    slv_base_sw = 7'h08;
    slv_size_sw = 4'h2;
    $display("test sys done");
  endtask
  task automatic t_tie;
    m_addr = 20'h10000;
    go = 1'b1;
    // the processor request lands on the edge at which the system side would be granted
    repeat (7) @(negedge sys_clk);
    cpu_op(20'h00020, 1'b0, 1'b0, 3'b100, 4);
    wait_for(sys_grant, 1'b1, 12);
    chk(sys_grant, 1'b1);
    wait_for(sys_grant, 1'b0, 20);
    chk(arb_state, 2'h0);
    go = 1'b0;
    repeat (4) @(negedge sys_clk);
    $display("test tie done");
  endtask
  task automatic t_rst(input logic aux);
    if (aux) begin
      aux_rst_n = 1'b0;
      wait_for(cpu_rst, 1'b1, 8);
    end
    chk(cpu_rst, 1'b1);
    chk(sys_init_n, 1'b0);
    chk(sys_grant, 1'b0);
    if (aux) aux_rst_n = 1'b1;
    wait_for(cpu_rst, 1'b0, 20);
    chk(sys_init_n, 1'b1);
    chk(cpu_grant, 1'b1);
    chk(arb_state, 2'h0);
    $display("test reset done");
  endtask
  task automatic stop_test;
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 6000) begin
      error_cnt++;
      stop_test();
    end
  end
  initial begin
    repeat (8) @(negedge sys_clk);
    rstn = 1'b1;
    t_rst(1'b0);
    t_map();
    t_sys();
    t_tie();
    t_rst(1'b1);
    stop_test();
  end
endmodule // tb
`default_nettype wire

// >>> rtl/dpa_arbiter.v
/*
  dpa_arbiter.v: dual-port RAM bus arbiter with processor-side decoder,
  slave window decoder/translator, wait-state generator and reset
  distribution.
  Assumes the processor request signals are synchronous to sys_clk; the
  system-bus request, strap switches and auxiliary reset come from pins.
*/
// How it works
// (RL1) rom starts at FF000, FE000 or FC000 for 2K, 4K, 8K parts
// (RL2) expansion eprom fitted moves the rom base to F8000
// (RL3) rom always covers the reset vector at FFFF0
// (RL4) ram decodes from zero: 32K base, 64K with expansion ram
// (RL5) arbiter holds idle, cpu busy or system busy
// (RL6) with nothing pending the bus stays owned by the processor
// (RL7) cpu ram request goes idle to cpu busy, waiting out system use
// (RL8) cpu done returns the bus to idle
// (RL9) system request reaches system busy in about 150 ns, then idle
// (RL10) cpu system-bus access passes through idle, at least 200 ns
// (RL11) slave decoder is separate and placeable anywhere in 1 MB
// (RL12) slave base on 8K or 16K boundary, never across 128K
// (RL13) slave size in 8K or 16K steps; rest stays cpu only
// (RL14) slave addresses translate to ram offset zero upward
// (RL15) wait states: ram write three, ram read two, rom or io one
// (RL16) buses talk only to neighbours and run independently
// (RL17) system bus moves bytes and words
// (RL18) power-up gives a clocked reset and drives init low
// (RL19) auxiliary reset low at any time repeats initialisation
// (RL20) control logic runs on the single ram-side clock
// (RL21) simultaneous requests: processor wins, never both granted
// (RL22) reset forces idle, processor owned, no system grant
`timescale 1ns/100ps
`default_nettype none
`include "dpa_map.vh"
module dpa_arbiter #(
  parameter ADDR_W = 20,
  parameter SYS_CYC = ((`DPA_SYS_GRANT_NS * `DPA_CLK_KHZ) / 1000000 < 1) ? 1 :
                      (`DPA_SYS_GRANT_NS * `DPA_CLK_KHZ) / 1000000,
  parameter XCHG_CYC = ((`DPA_XCHG_MIN_NS * `DPA_CLK_KHZ) + 999999) / 1000000
) (
  input  wire              sys_clk,
  input  wire              rstn,
  input  wire              aux_rst_n,
  input  wire              cpu_req,
  input  wire              cpu_wr,
  input  wire              cpu_io,
  input  wire [ADDR_W-1:0] cpu_addr,
  input  wire              cpu_done,
  input  wire [1:0]        rom_size_sel,
  input  wire              exp_eprom_fit,
  input  wire              exp_ram_fit,
  input  wire              sys_req,
  input  wire              sys_wr,
  input  wire              sys_byte,
  input  wire              sys_done,
  input  wire [ADDR_W-1:0] sys_addr,
  input  wire [6:0]        slv_base_sw,
  input  wire [3:0]        slv_size_sw,
  output reg               cpu_ready,
  output reg               cpu_ram_sel,
  output reg               cpu_rom_sel,
  output reg               cpu_ext_sel,
  output reg               cpu_grant,
  output reg               sys_grant,
  output reg               sys_hit,
  output reg               sys_byte_xfer,
  output reg  [15:0]       ram_addr,
  output reg  [1:0]        arb_state,
  output reg               cpu_rst,
  output reg               sys_init_n
);
  // counters sized for the derived cycle figures
  localparam CW = 4;

  wire         aux_rst_s;
  wire         sys_req_s;
  wire         sys_done_s;
  reg  [1:0]   state_r;
  reg  [1:0]   state_nxt;
  reg  [CW-1:0] sys_cnt_r;
  reg  [CW-1:0] xchg_cnt_r;
  reg  [1:0]   wait_cnt_r;
  reg          cyc_act_r;
  reg  [2:0]   rst_cnt_r;
  reg  [19:0]  rom_base;
  reg          ram_hit;
  reg          rom_hit;
  reg  [19:0]  slv_base;
  reg  [19:0]  slv_len;
  reg  [19:0]  slv_off;
  reg          slv_in;
  reg  [1:0]   wait_need;

  dpa_sync #(.RST_VAL(1'b1)) u_sync_aux (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .din     (aux_rst_n),
    .dout    (aux_rst_s)
  );
  dpa_sync #(.RST_VAL(1'b0)) u_sync_req (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .din     (sys_req),
    .dout    (sys_req_s)
  );
  dpa_sync #(.RST_VAL(1'b0)) u_sync_done (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .din     (sys_done),
    .dout    (sys_done_s)
  );

  // processor-side decode
  always @* begin
    case (rom_size_sel)
      `DPA_ROM_SEL_2K: rom_base = `DPA_ROM_BASE_2K; // RL1
      `DPA_ROM_SEL_4K: rom_base = `DPA_ROM_BASE_4K; // RL1
      default:         rom_base = `DPA_ROM_BASE_8K; // RL1
    endcase
    if (exp_eprom_fit) begin
      rom_base = `DPA_ROM_BASE_EXP; // RL2
    end
    // rom runs to the top, so the reset vector always lands in it
    rom_hit = ({{(20-ADDR_W){1'b0}}, cpu_addr} >= rom_base); // RL3
    ram_hit = ({{(20-ADDR_W){1'b0}}, cpu_addr} <=
               (exp_ram_fit ? `DPA_RAM_TOP_EXP : `DPA_RAM_TOP_BASE)); // RL4
  end

  // slave window: base and size granules of 8K, or 16K with expansion ram
  always @* begin
    if (exp_ram_fit) begin
      slv_base = {slv_base_sw[6:1], 14'h0000}; // RL12
      slv_len  = {2'h0, slv_size_sw, 14'h0000}; // RL13
    end else begin
      slv_base = {slv_base_sw, 13'h0000}; // RL12 RL11
      slv_len  = {3'h0, slv_size_sw, 13'h0000}; // RL13
    end
    slv_off = {{(20-ADDR_W){1'b0}}, sys_addr} - slv_base; // RL14
    // window clipped at the 128K boundary above its base
    slv_in  = ({{(20-ADDR_W){1'b0}}, sys_addr} >= slv_base) &&
              (slv_off < slv_len) &&
              (sys_addr[19:17] == slv_base[19:17]) && // RL12
              (slv_off <= (exp_ram_fit ? `DPA_RAM_TOP_EXP : `DPA_RAM_TOP_BASE)); // RL13
  end

  // ownership machine; processor wins ties
  always @* begin
    state_nxt = state_r;
    case (state_r)
      `DPA_ST_IDLE: begin
        if (cpu_req && ram_hit && !rom_hit && !cpu_io) begin
          state_nxt = `DPA_ST_CPU_BUSY; // RL7 RL21
        end else if (sys_req_s && slv_in && sys_cnt_r >= SYS_CYC[CW-1:0] - 4'h1) begin
          state_nxt = `DPA_ST_SYS_BUSY; // RL9
        end
      end
      `DPA_ST_CPU_BUSY: begin
        if (cpu_done) begin
          state_nxt = `DPA_ST_IDLE; // RL8
        end
      end
      `DPA_ST_SYS_BUSY: begin
        if (sys_done_s || !sys_req_s) begin
          state_nxt = `DPA_ST_IDLE; // RL9
        end
      end
      default: state_nxt = `DPA_ST_IDLE;
    endcase
  end

  always @* begin
    if (!cpu_io && rom_hit) begin
      wait_need = `DPA_WAIT_ROM_IO;
    end else if (!cpu_io && ram_hit) begin
      wait_need = cpu_wr ? `DPA_WAIT_RAM_WR : `DPA_WAIT_RAM_RD; // RL15
    end else begin
      wait_need = `DPA_WAIT_ROM_IO; // RL15
    end
  end

  wire int_rst = !aux_rst_s; // RL19
  wire cpu_ext = cpu_req && !cpu_io && !rom_hit && !ram_hit;

  always @(posedge sys_clk or negedge rstn) begin // RL20
    if (!rstn) begin
      state_r       <= `DPA_ST_IDLE; // RL22
      sys_cnt_r     <= {CW{1'b0}};
      xchg_cnt_r    <= {CW{1'b0}};
      wait_cnt_r    <= 2'h0;
      cyc_act_r     <= 1'b0;
      rst_cnt_r     <= 3'h0;
      cpu_ready     <= 1'b0;
      cpu_ram_sel   <= 1'b0;
      cpu_rom_sel   <= 1'b0;
      cpu_ext_sel   <= 1'b0;
      cpu_grant     <= 1'b1;
      sys_grant     <= 1'b0;
      sys_hit       <= 1'b0;
      sys_byte_xfer <= 1'b0;
      ram_addr      <= 16'h0000;
      arb_state     <= `DPA_ST_IDLE;
      cpu_rst       <= 1'b1;
      sys_init_n    <= 1'b0;
    end else if (int_rst) begin
      state_r       <= `DPA_ST_IDLE; // RL19 RL22
      sys_cnt_r     <= {CW{1'b0}};
      xchg_cnt_r    <= {CW{1'b0}};
      wait_cnt_r    <= 2'h0;
      cyc_act_r     <= 1'b0;
      rst_cnt_r     <= 3'h0;
      cpu_ready     <= 1'b0;
      cpu_ram_sel   <= 1'b0;
      cpu_rom_sel   <= 1'b0;
      cpu_ext_sel   <= 1'b0;
      cpu_grant     <= 1'b1;
      sys_grant     <= 1'b0;
      sys_hit       <= 1'b0;
      sys_byte_xfer <= 1'b0;
      arb_state     <= `DPA_ST_IDLE;
      cpu_rst       <= 1'b1;
      sys_init_n    <= 1'b0;
    end else begin
      // reset held a few clocks after release so it leaves on a clean edge
      if (rst_cnt_r != `DPA_RST_SYNC_CYC) begin
        rst_cnt_r <= rst_cnt_r + 3'h1;
      end
      cpu_rst    <= (rst_cnt_r != `DPA_RST_SYNC_CYC); // RL18
      sys_init_n <= (rst_cnt_r == `DPA_RST_SYNC_CYC); // RL18
      state_r    <= state_nxt; // RL5
      arb_state  <= state_nxt;
      cpu_grant  <= (state_nxt != `DPA_ST_SYS_BUSY); // RL6
      sys_grant  <= (state_nxt == `DPA_ST_SYS_BUSY); // RL21
      sys_hit    <= sys_req_s && slv_in;
      if (state_nxt == `DPA_ST_SYS_BUSY && state_r == `DPA_ST_IDLE) begin
        ram_addr      <= slv_off[15:0]; // RL14
        sys_byte_xfer <= sys_byte; // RL17
      end
      // the cpu address reaches the ram only once the bus is its own
      if (state_nxt == `DPA_ST_CPU_BUSY && state_r == `DPA_ST_IDLE) begin
        ram_addr <= cpu_addr[15:0]; // RL4
      end
      // count the request settle time while the slave waits
      if (state_r == `DPA_ST_IDLE && sys_req_s && slv_in) begin
        if (sys_cnt_r != 4'hF) begin
          sys_cnt_r <= sys_cnt_r + 4'h1;
        end
      end else begin
        sys_cnt_r <= {CW{1'b0}};
      end
      // processor cycle: decode latched, wait states then ready pulse
      cpu_ready <= 1'b0;
      if (!cyc_act_r && cpu_req && !cpu_rst) begin
        cpu_ram_sel <= ram_hit && !rom_hit && !cpu_io;
        cpu_rom_sel <= rom_hit && !cpu_io;
        cpu_ext_sel <= cpu_ext; // RL10 RL16
        cyc_act_r  <= 1'b1;
        wait_cnt_r <= wait_need;
        xchg_cnt_r <= XCHG_CYC[CW-1:0];
      end else if (cyc_act_r) begin
        if (cpu_ext_sel) begin
          // pass-through leaves the ownership machine idle
          if (xchg_cnt_r != {CW{1'b0}}) begin
            xchg_cnt_r <= xchg_cnt_r - 4'h1; // RL10
          end else if (cpu_done) begin
            cyc_act_r   <= 1'b0;
            cpu_ready   <= 1'b1;
            cpu_ext_sel <= 1'b0;
          end
        end else if (cpu_ram_sel && state_r != `DPA_ST_CPU_BUSY) begin
          wait_cnt_r <= wait_cnt_r; // RL7
        end else if (wait_cnt_r != 2'h0) begin
          wait_cnt_r <= wait_cnt_r - 2'h1; // RL15
        end else begin
          cpu_ready   <= 1'b1;
          cyc_act_r   <= 1'b0;
          cpu_ram_sel <= 1'b0;
          cpu_rom_sel <= 1'b0;
        end
      end
    end
  end
endmodule // dpa_arbiter
`default_nettype wire

// >>> rtl/dpa_map.vh
/*
  dpa_map.vh: constants for the dual-port RAM arbiter: memory map bounds,
  rom size selects, wait-state counts, timing figures and states.
  Assumes inclusion by bare name from the rtl files.
*/
`ifndef DPA_MAP_VH
`define DPA_MAP_VH

`define DPA_ROM_BASE_2K   20'hFF000
`define DPA_ROM_BASE_4K   20'hFE000
`define DPA_ROM_BASE_8K   20'hFC000
`define DPA_ROM_BASE_EXP  20'hF8000
`define DPA_RESET_VECTOR  20'hFFFF0
`define DPA_RAM_TOP_BASE  20'h07FFF
`define DPA_RAM_TOP_EXP   20'h0FFFF

`define DPA_ROM_SEL_2K    2'h0
`define DPA_ROM_SEL_4K    2'h1
`define DPA_ROM_SEL_8K    2'h2

`define DPA_WAIT_RAM_WR   2'h3
`define DPA_WAIT_RAM_RD   2'h2
`define DPA_WAIT_ROM_IO   2'h1

`define DPA_ST_IDLE       2'h0
`define DPA_ST_CPU_BUSY   2'h1
`define DPA_ST_SYS_BUSY   2'h2

`define DPA_CLK_KHZ       25000
`define DPA_SYS_GRANT_NS  150
`define DPA_XCHG_MIN_NS   200
`define DPA_RST_SYNC_CYC  4

`endif

// >>> rtl/dpa_sync.v
/*
  dpa_sync.v: three-flop input synchroniser; the output changes only when
  the second and third stages agree.
  Assumes the input is asynchronous to sys_clk.
*/
`timescale 1ns/100ps
`default_nettype none
module dpa_sync #(
  parameter RST_VAL = 1'b0
) (
  input  wire sys_clk,
  input  wire rstn,
  input  wire din,
  output reg  dout
);
  reg s1_r;
  reg s2_r;
  reg s3_r;

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
      dout <= RST_VAL;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        dout <= s3_r;
      end
    end
  end
endmodule // dpa_sync
`default_nettype wire
